// ---- iolc_defs.vh ----
`ifndef IOLC_DEFS_VH
`define IOLC_DEFS_VH
// ==========================================================
// states
`define IOLC_ST_INIT 3'h0
`define IOLC_ST_RESET 3'h1
`define IOLC_ST_HOLD 3'h2
`define IOLC_ST_READY 3'h3
`define IOLC_ST_OPER 3'h4
`define IOLC_ST_FAIL 3'h5
`define IOLC_ST_FAULT 3'h6
// ==========================================================
// message codes
`define IOLC_MSG_STATUS 4'h0
`define IOLC_MSG_OBINIT 4'h1
`define IOLC_MSG_SYSTAB 4'h2
`define IOLC_MSG_ENABLE 4'h3
`define IOLC_MSG_PRESET 4'h4
`define IOLC_MSG_PCLEAR 4'h5
`define IOLC_MSG_MODIFY 4'h6
`define IOLC_MSG_QUIESCE 4'h7
`define IOLC_MSG_HOSTEXEC 4'h8
`define IOLC_MSG_PEEREXEC 4'h9
`define IOLC_MSG_NONEXEC 4'hA
// ==========================================================
// action codes
`define IOLC_ACT_NONE 3'h0
`define IOLC_ACT_RESP 3'h1
`define IOLC_ACT_RESPQ 3'h2
`define IOLC_ACT_REJ 3'h3
`define IOLC_ACT_DEFER 3'h4
`define IOLC_ACT_DISC 3'h5
`define IOLC_ACT_RETRY 3'h6
`define IOLC_ACT_RELEASE 3'h7
// ==========================================================
// queue constants
`define IOLC_EMPTY_MARK 32'hFFFFFFFF
`define IOLC_INIT_CYCLES 8'h10
`endif

// ---- iolc_sync.v ----
`timescale 1ns/100ps
// ==========================================================
// two-flop level synchroniser
module iolc_sync (
  sys_clk,
  rst_b,
  d_in,
  q_out
);
  input wire sys_clk;
  input wire rst_b;
  input wire d_in;
  output wire q_out;
  reg s1_r;
  reg s2_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
    end
  end
  assign q_out = s2_r;
endmodule

// ---- iolc_init_seq.v ----
`timescale 1ns/100ps
`include "iolc_defs.vh"
// ==========================================================
// queue initialisation sequencer
module iolc_init_seq #(
  parameter CYC_W = 8
) (
  sys_clk,
  rst_b,
  start,
  busy,
  done
);
  input wire sys_clk;
  input wire rst_b;
  input wire start;
  output reg busy;
  output reg done;
  reg [CYC_W-1:0] cnt_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= {CYC_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= `IOLC_INIT_CYCLES;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_r == {CYC_W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule

// ---- iolc_lifecycle.v ----
`timescale 1ns/100ps
`include "iolc_defs.vh"
module iolc_lifecycle #(
  parameter FA_W = 32
) (
  sys_clk,
  rst_b,
  hard_reset,
  soft_fail,
  hard_fail,
  hard_fail_repaired,
  msg_valid,
  msg_code,
  msg_frame_address,
  host_able,
  ob_list_empty,
  ob_list_head,
  ob_read,
  state_out,
  act_valid,
  act_code,
  act_state,
  act_frame_address,
  free_return,
  reject_reply,
  logical_cfg_clear,
  ext_conn_clear,
  queue_init,
  deferred_release,
  deferred_flush,
  ob_read_data
);
  input wire sys_clk;
  input wire rst_b;
  input wire hard_reset;
  input wire soft_fail;
  input wire hard_fail;
  input wire hard_fail_repaired;
  input wire msg_valid;
  input wire [3:0] msg_code;
  input wire [FA_W-1:0] msg_frame_address;
  input wire host_able;
  input wire ob_list_empty;
  input wire [FA_W-1:0] ob_list_head;
  input wire ob_read;
  output reg [2:0] state_out;
  output reg act_valid;
  output reg [2:0] act_code;
  output reg [2:0] act_state;
  output reg [FA_W-1:0] act_frame_address;
  output reg free_return;
  output reg reject_reply;
  output reg logical_cfg_clear;
  output reg ext_conn_clear;
  output reg queue_init;
  output reg deferred_release;
  output reg deferred_flush;
  output reg [FA_W-1:0] ob_read_data;

  // ==========================================================
  // pin synchronisers
  wire hrst_s;
  wire sfail_s;
  wire hfail_s;
  wire repair_s;
  iolc_sync u_sync_hrst (.sys_clk(sys_clk), .rst_b(rst_b), .d_in(hard_reset), .q_out(hrst_s));
  iolc_sync u_sync_sf (.sys_clk(sys_clk), .rst_b(rst_b), .d_in(soft_fail), .q_out(sfail_s));
  iolc_sync u_sync_hf (.sys_clk(sys_clk), .rst_b(rst_b), .d_in(hard_fail), .q_out(hfail_s));
  iolc_sync u_sync_rp (.sys_clk(sys_clk), .rst_b(rst_b),
    .d_in(hard_fail_repaired), .q_out(repair_s));

  // edge detectors idle low like the pins, so reset makes no false event
  reg hrst_d_r;
  reg sfail_d_r;
  reg hfail_d_r;
  reg repair_d_r;
  wire hrst_ev = hrst_s & ~hrst_d_r;
  wire sfail_ev = sfail_s & ~sfail_d_r;
  wire hfail_ev = hfail_s & ~hfail_d_r;
  wire repair_ev = repair_s & ~repair_d_r;

  // ==========================================================
  // init sequencer
  reg init_start_r;
  wire init_busy;
  wire init_done;
  iolc_init_seq u_init (.sys_clk(sys_clk), .rst_b(rst_b), .start(init_start_r),
    .busy(init_busy), .done(init_done));

  // ==========================================================
  // state decision
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] act_nxt;
  reg cfg_clr_nxt;
  reg ext_clr_nxt;
  reg ev_nxt;
  reg [2:0] msg_act;
  reg [2:0] msg_state;
  reg msg_cfg;
  reg msg_ext;

  always @* begin
    msg_act = `IOLC_ACT_DISC;
    msg_state = state_r;
    msg_cfg = 1'b0;
    msg_ext = 1'b0;
    case (msg_code)
      `IOLC_MSG_STATUS: begin
        if (state_r == `IOLC_ST_FAIL || state_r == `IOLC_ST_FAULT) begin
          msg_act = `IOLC_ACT_RESPQ;
        end else begin
          msg_act = `IOLC_ACT_RESP;
        end
      end
      `IOLC_MSG_OBINIT: begin
        case (state_r)
          `IOLC_ST_RESET: begin
            msg_act = `IOLC_ACT_RESP;
            msg_state = `IOLC_ST_HOLD;
          end
          `IOLC_ST_FAIL: msg_act = `IOLC_ACT_RESPQ;
          `IOLC_ST_FAULT: msg_act = `IOLC_ACT_DISC;
          default: msg_act = `IOLC_ACT_RESP;
        endcase
      end
      `IOLC_MSG_SYSTAB: begin
        case (state_r)
          `IOLC_ST_HOLD: begin
            msg_act = `IOLC_ACT_RESP;
            msg_state = `IOLC_ST_READY;
          end
          `IOLC_ST_READY, `IOLC_ST_OPER: msg_act = `IOLC_ACT_RESP;
          default: msg_act = `IOLC_ACT_DISC;
        endcase
      end
      `IOLC_MSG_ENABLE: begin
        case (state_r)
          `IOLC_ST_READY: begin
            msg_act = `IOLC_ACT_RESP;
            msg_state = `IOLC_ST_OPER;
          end
          `IOLC_ST_HOLD, `IOLC_ST_OPER: msg_act = `IOLC_ACT_REJ;
          default: msg_act = `IOLC_ACT_DISC;
        endcase
      end
      `IOLC_MSG_PRESET: begin
        if (state_r != `IOLC_ST_FAULT) begin
          msg_act = `IOLC_ACT_RESP;
          msg_state = `IOLC_ST_INIT;
          msg_cfg = 1'b1;
          msg_ext = 1'b1;
        end
      end
      `IOLC_MSG_PCLEAR, `IOLC_MSG_MODIFY: begin
        case (state_r)
          `IOLC_ST_HOLD: begin
            msg_act = `IOLC_ACT_RESP;
            msg_ext = 1'b1;
          end
          `IOLC_ST_READY, `IOLC_ST_OPER, `IOLC_ST_FAIL: begin
            msg_act = `IOLC_ACT_RESP;
            msg_state = `IOLC_ST_HOLD;
            msg_ext = 1'b1;
          end
          default: msg_act = `IOLC_ACT_DISC;
        endcase
      end
      `IOLC_MSG_QUIESCE: begin
        case (state_r)
          `IOLC_ST_OPER: begin
            msg_act = `IOLC_ACT_RESP;
            msg_state = `IOLC_ST_READY;
          end
          `IOLC_ST_READY: msg_act = `IOLC_ACT_RESP;
          `IOLC_ST_HOLD: msg_act = `IOLC_ACT_REJ;
          default: msg_act = `IOLC_ACT_DISC;
        endcase
      end
      `IOLC_MSG_HOSTEXEC: begin
        if (state_r == `IOLC_ST_HOLD || state_r == `IOLC_ST_READY ||
            state_r == `IOLC_ST_OPER) begin
          msg_act = `IOLC_ACT_RESP;
        end
      end
      `IOLC_MSG_PEEREXEC: begin
        if (state_r == `IOLC_ST_OPER) begin
          msg_act = `IOLC_ACT_RESP;
        end else if (state_r == `IOLC_ST_READY) begin
          msg_act = `IOLC_ACT_DEFER;
        end
      end
      `IOLC_MSG_NONEXEC: begin
        if (state_r == `IOLC_ST_OPER) begin
          msg_act = `IOLC_ACT_RESP;
        end
      end
      default: msg_act = `IOLC_ACT_DISC;
    endcase
    if (state_r == `IOLC_ST_INIT) begin
      msg_act = `IOLC_ACT_DISC;
      msg_state = state_r;
      msg_cfg = 1'b0;
      msg_ext = 1'b0;
    end
  end

  // event priority: hard reset, hard fail, repair, soft fail, init done, message
  always @* begin
    state_nxt = state_r;
    act_nxt = `IOLC_ACT_NONE;
    cfg_clr_nxt = 1'b0;
    ext_clr_nxt = 1'b0;
    ev_nxt = 1'b0;
    if (hrst_ev) begin
      ev_nxt = 1'b1;
      state_nxt = `IOLC_ST_INIT;
      if (state_r == `IOLC_ST_READY || state_r == `IOLC_ST_OPER ||
          state_r == `IOLC_ST_FAIL || state_r == `IOLC_ST_FAULT) begin
        cfg_clr_nxt = 1'b1;
        ext_clr_nxt = 1'b1;
      end
    end else if (hfail_ev && state_r != `IOLC_ST_FAULT) begin
      ev_nxt = 1'b1;
      state_nxt = `IOLC_ST_FAULT;
    end else if (repair_ev && state_r == `IOLC_ST_FAULT) begin
      ev_nxt = 1'b1;
      state_nxt = `IOLC_ST_FAIL;
    end else if (sfail_ev && state_r != `IOLC_ST_FAIL && state_r != `IOLC_ST_FAULT) begin
      ev_nxt = 1'b1;
      if (state_r == `IOLC_ST_INIT) begin
        act_nxt = `IOLC_ACT_RETRY;
      end else begin
        state_nxt = `IOLC_ST_FAIL;
      end
    end else if (init_done && state_r == `IOLC_ST_INIT) begin
      ev_nxt = 1'b1;
      state_nxt = `IOLC_ST_RESET;
    end else if (msg_valid) begin
      ev_nxt = 1'b1;
      act_nxt = msg_act;
      state_nxt = msg_state;
      cfg_clr_nxt = msg_cfg;
      ext_clr_nxt = msg_ext;
    end
  end

  // ==========================================================
  // deferred message bookkeeping
  reg defer_pend_r;
  wire leave_ready = (state_r == `IOLC_ST_READY) && (state_nxt != `IOLC_ST_READY);
  wire to_oper = leave_ready && (state_nxt == `IOLC_ST_OPER);
  wire defer_now = ev_nxt && (act_nxt == `IOLC_ACT_DEFER);

  // ==========================================================
  // queue setup flag
  // setup stops as soon as init is left, e.g. on a hard failure mid-setup
  wire in_init_nxt = (state_nxt == `IOLC_ST_INIT);
  wire queue_init_nxt = (init_busy | init_start_r) & in_init_nxt;

  // ==========================================================
  // registers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= `IOLC_ST_INIT;
      state_out <= `IOLC_ST_INIT;
      hrst_d_r <= 1'b0;
      sfail_d_r <= 1'b0;
      hfail_d_r <= 1'b0;
      repair_d_r <= 1'b0;
      init_start_r <= 1'b1;
      defer_pend_r <= 1'b0;
      act_valid <= 1'b0;
      act_code <= `IOLC_ACT_NONE;
      act_state <= `IOLC_ST_INIT;
      act_frame_address <= {FA_W{1'b0}};
      free_return <= 1'b0;
      reject_reply <= 1'b0;
      logical_cfg_clear <= 1'b0;
      ext_conn_clear <= 1'b0;
      queue_init <= 1'b0;
      deferred_release <= 1'b0;
      deferred_flush <= 1'b0;
      ob_read_data <= `IOLC_EMPTY_MARK;
    end else begin
      hrst_d_r <= hrst_s;
      sfail_d_r <= sfail_s;
      hfail_d_r <= hfail_s;
      repair_d_r <= repair_s;
      state_r <= state_nxt;
      state_out <= state_nxt;
      // entering init, or retrying it, restarts the queue setup
      init_start_r <= (state_nxt == `IOLC_ST_INIT && state_r != `IOLC_ST_INIT) ||
        (act_nxt == `IOLC_ACT_RETRY);
      queue_init <= queue_init_nxt;
      act_valid <= ev_nxt;
      act_code <= act_nxt;
      act_state <= state_nxt;
      if (msg_valid) begin
        act_frame_address <= msg_frame_address;
      end
      free_return <= ev_nxt && (act_nxt == `IOLC_ACT_DISC);
      reject_reply <= ev_nxt && (act_nxt == `IOLC_ACT_REJ);
      logical_cfg_clear <= cfg_clr_nxt;
      ext_conn_clear <= ext_clr_nxt;
      deferred_release <= to_oper && (defer_pend_r || defer_now);
      deferred_flush <= leave_ready && !to_oper && defer_pend_r;
      if (leave_ready) begin
        defer_pend_r <= 1'b0;
      end else if (defer_now) begin
        defer_pend_r <= 1'b1;
      end
      if (ob_read) begin
        ob_read_data <= ob_list_empty ? `IOLC_EMPTY_MARK : ob_list_head;
      end
    end
  end
endmodule

// ---- iolc_lifecycle_asserts.sv ----
`timescale 1ns/100ps
`include "iolc_defs.vh"
// ====
// lifecycle checker
module iolc_lifecycle_chk #(
  parameter FA_W = 32
) (
  input wire sys_clk,
  input wire rst_b,
  input wire hard_reset,
  input wire soft_fail,
  input wire hard_fail,
  input wire hard_fail_repaired,
  input wire msg_valid,
  input wire [3:0] msg_code,
  input wire ob_read,
  input wire ob_list_empty,
  input wire [2:0] state_out,
  input wire act_valid,
  input wire [2:0] act_code,
  input wire [2:0] act_state,
  input wire free_return,
  input wire reject_reply,
  input wire logical_cfg_clear,
  input wire ext_conn_clear,
  input wire queue_init,
  input wire [FA_W-1:0] ob_read_data
);
  reg [2:0] quiet_r;
  wire pin_any = hard_reset | soft_fail | hard_fail | hard_fail_repaired;
  wire take = msg_valid && quiet_r == 3'h7 && !pin_any && state_out != `IOLC_ST_INIT;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_r <= 3'h0;
    end else if (pin_any) begin
      quiet_r <= 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_table_load: assert property (
    take && state_out == `IOLC_ST_HOLD && msg_code == `IOLC_MSG_SYSTAB |=>
    act_valid && act_code == `IOLC_ACT_RESP && act_state == `IOLC_ST_READY)
    else $error("table load missed ready");
  a_enable_reject: assert property (
    take && state_out == `IOLC_ST_HOLD && msg_code == `IOLC_MSG_ENABLE |=>
    reject_reply && act_code == `IOLC_ACT_REJ && state_out == `IOLC_ST_HOLD)
    else $error("enable in hold not rejected");
  a_fault_discard: assert property (
    take && state_out == `IOLC_ST_FAULT && msg_code != `IOLC_MSG_STATUS |=>
    free_return && !reject_reply && state_out == `IOLC_ST_FAULT)
    else $error("fault message not discarded");
  a_reset_tables: assert property (
    take && state_out != `IOLC_ST_FAULT && msg_code == `IOLC_MSG_PRESET |=>
    logical_cfg_clear && ext_conn_clear && state_out == `IOLC_ST_INIT)
    else $error("processor reset missed");
  a_clear_hold: assert property (
    take && (msg_code == `IOLC_MSG_PCLEAR || msg_code == `IOLC_MSG_MODIFY) &&
    state_out inside {`IOLC_ST_READY, `IOLC_ST_OPER, `IOLC_ST_FAIL} |=>
    ext_conn_clear && state_out == `IOLC_ST_HOLD)
    else $error("clear missed hold");
  a_nonexec_oper: assert property (
    take && msg_code == `IOLC_MSG_NONEXEC |=>
    free_return == ($past(state_out) != `IOLC_ST_OPER))
    else $error("non-exec handled wrongly");
  a_empty_read: assert property (
    ob_read && ob_list_empty |=> ob_read_data == 32'hFFFFFFFF)
    else $error("empty read not all ones");
  a_idle_queue: assert property (
    state_out != `IOLC_ST_INIT |-> !queue_init)
    else $error("queue init outside init");
  a_hard_fault: assert property (
    $rose(hard_fail) && quiet_r == 3'h7 |-> ##[1:8] state_out == `IOLC_ST_FAULT)
    else $error("hard failure missed fault");
  a_act_state: assert property (
    take |=> act_valid && act_state == state_out)
    else $error("taken message gave no action");
  a_init_tables: assert property (
    state_out == `IOLC_ST_INIT && $past(state_out) inside {`IOLC_ST_READY, `IOLC_ST_OPER,
    `IOLC_ST_FAIL, `IOLC_ST_FAULT} |-> logical_cfg_clear && ext_conn_clear)
    else $error("tables kept on entering init");
endmodule

// ---- iolc_host_model.sv ----
`timescale 1ns/100ps
`include "iolc_defs.vh"
// ====
// host side: message poster and outbound list
module iolc_host_model (
  input wire sys_clk,
  input wire [2:0] state_out,
  input wire ob_read,
  output logic msg_valid,
  output logic [3:0] msg_code,
  output logic [31:0] msg_frame_address,
  output wire ob_list_empty,
  output wire [31:0] ob_list_head
);
  logic [7:0] push_cnt = 8'h00;
  logic [7:0] pop_cnt = 8'h00;
  logic [31:0] idle_pat = 32'h5A5A5A5A;
  initial begin
    msg_valid = 1'b0;
    msg_code = 4'hF;
    msg_frame_address = 32'h0;
  end
  // an empty list shows no stale head
  assign ob_list_empty = (push_cnt == pop_cnt);
  assign ob_list_head = ob_list_empty ? idle_pat : {24'h000010, pop_cnt};
  always @(posedge sys_clk) begin
    idle_pat <= ~idle_pat;
    if (ob_read && !ob_list_empty) begin
      pop_cnt <= pop_cnt + 8'h01;
    end
  end
  task automatic ob_fill(input logic [7:0] n);
    push_cnt = push_cnt + n;
  endtask
  task automatic post(input logic [3:0] code, output logic [31:0] fa);
    fa = {28'h0000200, code};
    wait (state_out != `IOLC_ST_INIT);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    msg_code <= code;
    msg_frame_address <= fa;
    @(posedge sys_clk);
    msg_valid <= 1'b0;
    msg_code <= ~code;
    msg_frame_address <= ~fa;
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "iolc_defs.vh"
// ====
// lifecycle testbench
module testbench;
  localparam int FA_W = 32;
  logic sys_clk;
  logic rst_b;
  logic ob_read;
  logic host_able;
  logic [3:0] pins;
  logic msg_valid;
  logic [3:0] msg_code;
  logic [31:0] msg_frame_address;
  logic ob_list_empty;
  logic [31:0] ob_list_head;
  logic [2:0] state_out;
  logic [2:0] act_code;
  logic [2:0] act_state;
  logic act_valid, free_return, reject_reply, logical_cfg_clear, ext_conn_clear;
  logic queue_init, deferred_release, deferred_flush;
  logic [FA_W-1:0] act_frame_address;
  logic [FA_W-1:0] ob_read_data;
  int num_errors = 0;
  int checks_done = 0;
  wire hard_reset = pins[0];
  wire soft_fail = pins[1];
  wire hard_fail = pins[2];
  wire hard_fail_repaired = pins[3];
  iolc_lifecycle #(.FA_W(FA_W)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .hard_reset(hard_reset), .soft_fail(soft_fail),
    .hard_fail(hard_fail), .hard_fail_repaired(hard_fail_repaired),
    .msg_valid(msg_valid), .msg_code(msg_code), .msg_frame_address(msg_frame_address),
    .host_able(host_able), .ob_list_empty(ob_list_empty), .ob_list_head(ob_list_head),
    .ob_read(ob_read), .state_out(state_out), .act_valid(act_valid), .act_code(act_code),
    .act_state(act_state), .act_frame_address(act_frame_address),
    .free_return(free_return), .reject_reply(reject_reply),
    .logical_cfg_clear(logical_cfg_clear), .ext_conn_clear(ext_conn_clear),
    .queue_init(queue_init), .deferred_release(deferred_release),
    .deferred_flush(deferred_flush), .ob_read_data(ob_read_data));
  iolc_host_model host_u (.sys_clk(sys_clk), .state_out(state_out), .ob_read(ob_read),
    .msg_valid(msg_valid), .msg_code(msg_code), .msg_frame_address(msg_frame_address),
    .ob_list_empty(ob_list_empty), .ob_list_head(ob_list_head));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int n = 0; n < lim && state_out !== s; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(state_out, s);
  endtask
  task automatic do_msg(input logic [3:0] c, input logic [2:0] a, input logic [2:0] s);
    logic [31:0] fa;
    logic clr;
    clr = a != `IOLC_ACT_DISC && c inside {`IOLC_MSG_PRESET, `IOLC_MSG_PCLEAR, `IOLC_MSG_MODIFY};
    host_u.post(c, fa);
    #1;
    chk(act_valid, 1'b1);
    chk({act_code, act_state, state_out}, {a, s, s});
    chk(act_frame_address, fa);
    chk(free_return, a == `IOLC_ACT_DISC);
    chk(reject_reply, a == `IOLC_ACT_REJ);
    chk(ext_conn_clear, clr);
    chk(logical_cfg_clear, clr && c == `IOLC_MSG_PRESET);
  endtask
  task automatic sweep(input logic [43:0] row, input logic [2:0] s);
    logic [3:0] a;
    for (int c = 0; c < 11; c++) begin
      a = row[4*(10-c) +: 4];
      if (a != 4'h0) do_msg(c[3:0], a[2:0], s);
    end
  endtask
  task automatic pin(input int k, input logic [2:0] s);
    @(posedge sys_clk);
    pins[k] <= 1'b1;
    wait_st(s, 10);
    @(posedge sys_clk);
    pins[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk(state_out, s);
  endtask
  task automatic t_start;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(state_out, `IOLC_ST_INIT);
    chk(queue_init, 1'b1);
    chk(ob_read_data, 32'hFFFFFFFF);
    wait_st(`IOLC_ST_RESET, 40);
  endtask
  task automatic t_bringup;
    sweep(44'h10550555555, `IOLC_ST_RESET);
    do_msg(`IOLC_MSG_OBINIT, `IOLC_ACT_RESP, `IOLC_ST_HOLD);
    sweep(44'h11030113155, `IOLC_ST_HOLD);
    do_msg(`IOLC_MSG_SYSTAB, `IOLC_ACT_RESP, `IOLC_ST_READY);
    sweep(44'h11100001145, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_ENABLE, `IOLC_ACT_RESP, `IOLC_ST_OPER);
    chk(deferred_release, 1'b1);
    sweep(44'h11130000111, `IOLC_ST_OPER);
  endtask
  task automatic t_leave;
    do_msg(`IOLC_MSG_QUIESCE, `IOLC_ACT_RESP, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_PEEREXEC, `IOLC_ACT_DEFER, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_PCLEAR, `IOLC_ACT_RESP, `IOLC_ST_HOLD);
    chk(deferred_flush, 1'b1);
    do_msg(`IOLC_MSG_SYSTAB, `IOLC_ACT_RESP, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_ENABLE, `IOLC_ACT_RESP, `IOLC_ST_OPER);
    do_msg(`IOLC_MSG_MODIFY, `IOLC_ACT_RESP, `IOLC_ST_HOLD);
    do_msg(`IOLC_MSG_SYSTAB, `IOLC_ACT_RESP, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_PRESET, `IOLC_ACT_RESP, `IOLC_ST_INIT);
    wait_st(`IOLC_ST_RESET, 40);
  endtask
  task automatic t_fail;
    pin(1, `IOLC_ST_FAIL);
    sweep(44'h22550005555, `IOLC_ST_FAIL);
    do_msg(`IOLC_MSG_MODIFY, `IOLC_ACT_RESP, `IOLC_ST_HOLD);
    pin(1, `IOLC_ST_FAIL);
    pin(1, `IOLC_ST_FAIL);
    pin(2, `IOLC_ST_FAULT);
    sweep(44'h25555555555, `IOLC_ST_FAULT);
    pin(1, `IOLC_ST_FAULT);
    pin(2, `IOLC_ST_FAULT);
    pin(3, `IOLC_ST_FAIL);
    do_msg(`IOLC_MSG_PRESET, `IOLC_ACT_RESP, `IOLC_ST_INIT);
    pin(1, `IOLC_ST_INIT);
    wait_st(`IOLC_ST_RESET, 60);
  endtask
  task automatic t_hreset;
    do_msg(`IOLC_MSG_OBINIT, `IOLC_ACT_RESP, `IOLC_ST_HOLD);
    do_msg(`IOLC_MSG_SYSTAB, `IOLC_ACT_RESP, `IOLC_ST_READY);
    do_msg(`IOLC_MSG_ENABLE, `IOLC_ACT_RESP, `IOLC_ST_OPER);
    pin(0, `IOLC_ST_INIT);
    wait_st(`IOLC_ST_RESET, 40);
    pin(2, `IOLC_ST_FAULT);
    pin(0, `IOLC_ST_INIT);
    wait_st(`IOLC_ST_RESET, 40);
  endtask
  task automatic ob_rd(input logic [31:0] e);
    @(posedge sys_clk);
    ob_read <= 1'b1;
    @(posedge sys_clk);
    ob_read <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(ob_read_data, e);
  endtask
  task automatic t_outbound;
    host_u.ob_fill(8'h01);
    ob_rd(32'h00001000);
    ob_rd(32'hFFFFFFFF);
  endtask
  initial begin
    #(25 * 8000);
    num_errors++;
    test_done;
  end
  initial begin
    rst_b = 1'b0;
    pins = 4'h0;
    ob_read = 1'b0;
    host_able = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_start;
    t_bringup;
    t_leave;
    t_fail;
    t_hreset;
    t_outbound;
    test_done;
  end
endmodule
bind iolc_lifecycle iolc_lifecycle_chk #(.FA_W(FA_W)) chk_u (.sys_clk(sys_clk),
  .rst_b(rst_b), .hard_reset(hard_reset), .soft_fail(soft_fail), .hard_fail(hard_fail),
  .hard_fail_repaired(hard_fail_repaired), .msg_valid(msg_valid), .msg_code(msg_code),
  .ob_read(ob_read), .ob_list_empty(ob_list_empty), .state_out(state_out),
  .act_valid(act_valid), .act_code(act_code), .act_state(act_state),
  .free_return(free_return), .reject_reply(reject_reply),
  .logical_cfg_clear(logical_cfg_clear), .ext_conn_clear(ext_conn_clear),
  .queue_init(queue_init), .ob_read_data(ob_read_data));
